// File: logic/cec_regs.vh
// register map, field positions, reset values and clock ratios of the cascaded counter
`ifndef CEC_REGS_VH
`define CEC_REGS_VH

// register word offsets
`define CEC_CTRL_OFF 4'h0
`define CEC_PER_LO_OFF 4'h1
`define CEC_PER_HI_OFF 4'h2
`define CEC_DUTY_LO_OFF 4'h3
`define CEC_DUTY_HI_OFF 4'h4
`define CEC_STAT_OFF 4'h5

// control register fields
`define CEC_RUN_BIT 0
`define CEC_MODE_BIT 1
`define CEC_FFINIT_BIT 2
`define CEC_DVSEL_BIT 3
`define CEC_SRC_LSB 4
`define CEC_SRC_MSB 6

// status register fields
`define CEC_STAT_FF_BIT 16

// reset values
`define CEC_CTRL_RST 8'h00
`define CEC_PER_RST 16'hffff
`define CEC_DUTY_RST 16'h0000

// count source codes
`define CEC_SRC_DIV11 3'h0
`define CEC_SRC_DIV7 3'h1
`define CEC_SRC_DIV5 3'h2
`define CEC_SRC_DIV3 3'h3
`define CEC_SRC_FS 3'h4
`define CEC_SRC_DIV1 3'h5
`define CEC_SRC_FC 3'h6
`define CEC_SRC_EXT 3'h7

// prescaler taps: fc, or fs for the fs tap, over two to the power given
`define CEC_TAP_11 11
`define CEC_TAP_7 7
`define CEC_TAP_5 5
`define CEC_TAP_3 3
`define CEC_TAP_1 1
`define CEC_FS_TAP 3

// axi responses
`define CEC_RESP_OKAY 2'b00
`define CEC_RESP_SLVERR 2'b10

`endif

// File: logic/cec_top.v
// cascaded 16-bit event counter and pwm generator with an axi4-lite register slave
//
// Overview of operation
// - event mode: one 16-bit up-counter counts external input falling edges
// - while running, count equal to period pulses match irq and clears counter
// - after that clear, counting continues on later falling edges automatically
// - period register unbuffered, takes effect at once; avoid changing while running
// - pwm mode counts a selected prescaled clock or the external input
// - pwm: count equal to duty inverts the output flop, counting goes on
// - pwm: overflow inverts flop again, clears counter, pulses match irq
// - output flop starts from initial-level bit; reset clears it to zero
// - pwm pin always shows the inverse of the output flop
// - duty double-buffered: loads at pwm match irq when running, at once stopped
// - duty read during pwm shows old value until next match irq
// - stopping holds output level; initial-level change only in a later write
// - count sources: prescaled fc or fs taps; slow modes allow only fs sources and the external input
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "cec_regs.vh"

module cec_top #(
  parameter integer ADDR_W = 8 // axi address width
) (
  input wire aclk, // system clock, fc
  input wire aresetn, // synchronous reset, active low
  input wire external_count_input, // event input, counts on falling edge
  input wire fs_tick, // one pulse per low-frequency clock period
  input wire slow_mode, // high in slow run or slow idle mode
  output reg pwm_output_n, // pwm pin, inverse of the output flop
  output reg cascade_match_irq, // one-cycle match or overflow pulse
  input wire [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready // read data ready
);

  // register word index from a byte address, mapped flag alongside
  function [4:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      reg_index = {1'b0, addr[5:2]};
      if (addr[ADDR_W-1:2] > `CEC_STAT_OFF)
        reg_index = 5'h1f;
    end
  endfunction

  // software state
  reg [7:0] ctrl_reg;
  reg [15:0] period_reg;
  reg [15:0] duty_buf_reg;
  reg [15:0] duty_act_reg;

  // counting state
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg ff_reg;
  reg ff_next;
  reg irq_next;
  reg [10:0] pre_reg;
  reg [2:0] fs_div_reg;
  reg ext_prev_reg;

  // bus state
  reg aw_held_reg;
  reg w_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  // control fields shared by the counter and the source mux
  wire run = ctrl_reg[`CEC_RUN_BIT];
  wire pwm_mode = ctrl_reg[`CEC_MODE_BIT];
  wire [2:0] src_sel = ctrl_reg[`CEC_SRC_MSB:`CEC_SRC_LSB];

  // write commits once both address and data are held
  // a pending response holds off the commit, not the address or data stage
  wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [4:0] wr_idx = reg_index(aw_addr_reg);
  wire wr_lane0 = wr_go && w_strb_reg[0];
  wire wr_ctrl = wr_lane0 && (wr_idx == {1'b0, `CEC_CTRL_OFF});
  wire wr_per_lo = wr_lane0 && (wr_idx == {1'b0, `CEC_PER_LO_OFF});
  wire wr_per_hi = wr_lane0 && (wr_idx == {1'b0, `CEC_PER_HI_OFF});
  wire wr_duty_lo = wr_lane0 && (wr_idx == {1'b0, `CEC_DUTY_LO_OFF});
  wire wr_duty_hi = wr_lane0 && (wr_idx == {1'b0, `CEC_DUTY_HI_OFF});

  // prescaler taps: a tap fires when its low bits are all ones
  function tap;
    input [10:0] pre;
    input integer n;
    integer i;
    begin
      tap = 1'b1;
      for (i = 0; i < 11; i = i + 1)
        if (i < n && !pre[i])
          tap = 1'b0;
    end
  endfunction

  // fs divided by eight for the slowest low-frequency source
  wire fs_div_tick = fs_tick && (fs_div_reg == 3'h7);

  // falling edge seen by sampling once per clock; slow pulses assumed
  wire ext_fall = ext_prev_reg && !external_count_input;

  // source select, fc-derived taps are dead in the slow modes
  reg src_tick;
  always @*
  begin
    src_tick = 1'b0;
    case (src_sel)
      `CEC_SRC_DIV11:
        src_tick = (ctrl_reg[`CEC_DVSEL_BIT] || slow_mode) ? fs_div_tick :
          tap(pre_reg, `CEC_TAP_11);
      `CEC_SRC_DIV7: src_tick = !slow_mode && tap(pre_reg, `CEC_TAP_7);
      `CEC_SRC_DIV5: src_tick = !slow_mode && tap(pre_reg, `CEC_TAP_5);
      `CEC_SRC_DIV3: src_tick = !slow_mode && tap(pre_reg, `CEC_TAP_3);
      `CEC_SRC_FS: src_tick = fs_tick;
      `CEC_SRC_DIV1: src_tick = !slow_mode && tap(pre_reg, `CEC_TAP_1);
      `CEC_SRC_FC: src_tick = !slow_mode;
      `CEC_SRC_EXT: src_tick = ext_fall;
      default: src_tick = 1'b0;
    endcase
  end

  // event mode always counts external falling edges
  // pwm mode counts the selected source
  wire cnt_tick = pwm_mode ? src_tick : ext_fall;
  wire [15:0] cnt_inc = count_reg + 16'h0001;
  wire overflow = (count_reg == 16'hffff);

  // next counter, flop and match pulse
  always @*
  begin
    count_next = count_reg;
    ff_next = ff_reg;
    irq_next = 1'b0;
    if (!run)
    begin
      // stopped counter rests at zero, flop holds its level
      count_next = 16'h0000;
      // initial level taken on a write made from the stopped state
      // a write that stops the timer leaves the flop alone
      if (wr_ctrl)
        ff_next = w_data_reg[`CEC_FFINIT_BIT];
    end
    else if (cnt_tick)
    begin
      if (!pwm_mode)
      begin
        // match pulses the irq and clears the counter
        // counting resumes on the next edge with no software help
        if (cnt_inc == period_reg)
        begin
          count_next = 16'h0000;
          irq_next = 1'b1;
        end
        else
          count_next = cnt_inc;
      end
      else
      begin
        // duty match inverts the flop, counting goes on
        // overflow inverts again, clears and pulses the irq
        count_next = cnt_inc;
        irq_next = overflow;
        ff_next = ff_reg ^ overflow ^ (cnt_inc == duty_act_reg);
      end
    end
  end

  // prescaler and edge history run free so sources stay in phase
  // switching source while running may give one short first period
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_reg <= 11'h000;
      fs_div_reg <= 3'h0;
      ext_prev_reg <= 1'b1;
    end
    else
    begin
      pre_reg <= pre_reg + 11'h001;
      if (fs_tick)
        fs_div_reg <= fs_div_reg + 3'h1;
      ext_prev_reg <= external_count_input;
    end
  end

  // counter, flop and outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= 16'h0000;
      ff_reg <= 1'b0;
      pwm_output_n <= 1'b1;
      cascade_match_irq <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      ff_reg <= ff_next;
      // pin is the inverse of the flop, taken from its next value
      pwm_output_n <= !ff_next;
      cascade_match_irq <= irq_next;
    end
  end

  // software registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `CEC_CTRL_RST;
      period_reg <= `CEC_PER_RST;
      duty_buf_reg <= `CEC_DUTY_RST;
      duty_act_reg <= `CEC_DUTY_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= w_data_reg[7:0];
      // period bytes act at once, no shadow stage
      // a period set below the running count is only met after a wrap
      if (wr_per_lo)
        period_reg[7:0] <= w_data_reg[7:0];
      if (wr_per_hi)
        period_reg[15:8] <= w_data_reg[7:0];
      if (wr_duty_lo)
        duty_buf_reg[7:0] <= w_data_reg[7:0];
      if (wr_duty_hi)
        duty_buf_reg[15:8] <= w_data_reg[7:0];
      // buffer moves to active at the pwm match pulse, or freely when stopped
      // a buffer write on the match edge waits for the following match
      if (!run || (pwm_mode && irq_next))
        duty_act_reg <= duty_buf_reg;
    end
  end

  // write channel: address and data accepted in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CEC_RESP_OKAY;
    end
    else
    begin
      // ready is a one-cycle pulse, so each channel takes one item
      s_axi_awready <= !aw_held_reg && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_held_reg && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == 5'h1f || wr_idx == {1'b0, `CEC_STAT_OFF}) ?
          `CEC_RESP_SLVERR : `CEC_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  wire [4:0] rd_idx = reg_index(s_axi_araddr);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CEC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CEC_RESP_OKAY;
        case (rd_idx)
          {1'b0, `CEC_CTRL_OFF}: s_axi_rdata <= {24'h000000, ctrl_reg};
          {1'b0, `CEC_PER_LO_OFF}: s_axi_rdata <= {24'h000000, period_reg[7:0]};
          {1'b0, `CEC_PER_HI_OFF}: s_axi_rdata <= {24'h000000, period_reg[15:8]};
          // read shows the active stage, old value until the match pulse
          {1'b0, `CEC_DUTY_LO_OFF}: s_axi_rdata <= {24'h000000, duty_act_reg[7:0]};
          {1'b0, `CEC_DUTY_HI_OFF}: s_axi_rdata <= {24'h000000, duty_act_reg[15:8]};
          // status is read-only: flop level above the live count
          {1'b0, `CEC_STAT_OFF}: s_axi_rdata <= {15'h0000, ff_reg, count_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CEC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: tb/cec_top_monitor.sv
// port checker for the cascaded counter, bound to its top
`timescale 1ns/100ps
module cec_top_monitor (
  input wire aclk, // clock
  input wire aresetn, // reset, low
  input wire pwm_output_n, // pwm pin
  input wire cascade_match_irq, // match pulse
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wready, // w ready
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire [1:0] s_axi_bresp, // b resp
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire [31:0] s_axi_rdata // r data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // irq is a strobe, a level would re-enter the handler
  property p_irq;
    cascade_match_irq |=> !cascade_match_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq held");
  // reset must not be masked by the default disable
  property p_rst;
    disable iff (1'b0) !aresetn |=> pwm_output_n && !cascade_match_irq && !s_axi_bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("b dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("r dropped");
  property p_awgo;
    s_axi_awvalid && !s_axi_awready |-> ##[1:4] s_axi_awready;
  endproperty
  a_awgo: assert property (p_awgo) else $error("aw not taken");
  property p_artor;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_artor: assert property (p_artor) else $error("r late");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("ar during r");
  property p_brise;
    $rose(s_axi_bvalid) |-> $past(s_axi_wready, 2);
  endproperty
  a_brise: assert property (p_brise) else $error("b early");
  c_irq: cover property (cascade_match_irq);
  c_pwm: cover property ($fell(pwm_output_n));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind cec_top cec_top_monitor u_mon (.aclk, .aresetn, .pwm_output_n, .cascade_match_irq,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata);

// File: tb/cec_evt_src.sv
// external event pulse source driving the count input
`timescale 1ns/100ps
module cec_evt_src (
  input wire aclk, // clock
  input wire go, // start a burst
  input wire [15:0] n, // falling edges to send
  input wire slow, // four cycles per level
  output reg ext, // count input, idles high
  output wire busy // burst under way
);
  reg [15:0] left;
  reg [2:0] ph;
  assign busy = left != 16'h0000;
  initial
  begin
    ext = 1'b1;
    left = 16'h0000;
    ph = 3'h0;
  end
  // each level held two cycles or more
  always @(posedge aclk)
  begin
    if (go)
    begin
      left <= n;
      ph <= 3'h0;
    end
    else if (busy)
    begin
      ext <= slow ? ph[2] : ph[1];
      ph <= (ph == (slow ? 3'h7 : 3'h3)) ? 3'h0 : ph + 3'h1;
      if (ph == (slow ? 3'h7 : 3'h3))
        left <= left - 16'h0001;
    end
    else
      ext <= 1'b1;
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the cascaded counter
`timescale 1ns/100ps
module tb;
  reg aclk, aresetn, go, evs, fs, slw, awv, wv, br, arv, rr;
  reg [15:0] evn;
  reg [7:0] awa, ara;
  reg [31:0] wd, rd;
  reg [1:0] rs;
  reg [2:0] fsd;
  reg [41:0] rows [0:6];
  wire awr, wr_r, bv, arr, rv, pwm_n, irq, ext, evb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer err_total, samples_checked, irqs, i;
  cec_top u_dut (.aclk(aclk), .aresetn(aresetn), .external_count_input(ext),
    .fs_tick(fs), .slow_mode(slw), .pwm_output_n(pwm_n), .cascade_match_irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  cec_evt_src u_src (.aclk(aclk), .go(go), .n(evn), .slow(evs), .ext(ext), .busy(evb));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // slow clock tick every eighth cycle, irq tally
  always @(posedge aclk)
  begin
    fsd <= fsd + 3'h1;
    fs <= &fsd;
    if (irq === 1'b1)
      irqs <= irqs + 1;
  end
  task final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // each channel released only at its own handshake edge
  task wr(input [7:0] a, input [31:0] d);
    reg ga, gw;
  begin
    ga = 0;
    gw = 0;
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    while (!(ga && gw))
    begin
      @(posedge aclk);
      if (awv && awr) begin ga = 1; awv <= 0; end
      if (wv && wr_r) begin gw = 1; wv <= 0; end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    rs = bresp;
    br <= 0;
  end
  endtask
  task rdr(input [7:0] a);
  begin
    @(posedge aclk);
    ara <= a; arv <= 1; rr <= 1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge aclk); while (rv !== 1'b1);
    rd = rdata;
    rs = rresp;
    rr <= 0;
  end
  endtask
  task ev(input [15:0] k, input s);
  begin
    @(posedge aclk);
    evn <= k; evs <= s; go <= 1;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    while (evb) @(posedge aclk);
    repeat (4) @(posedge aclk);
  end
  endtask
  // start one source from a stopped counter, run w cycles, read the status
  task src_run(input [7:0] c, input integer w);
  begin
    wr(8'h00, 32'h02);
    wr(8'h00, {24'h000000, c});
    repeat (w) @(posedge aclk);
    rdr(8'h14);
  end
  endtask
  initial
  begin
    err_total = 0; samples_checked = 0; irqs = 0; fsd = 0; fs = 0; slw = 0;
    aresetn = 0; go = 0; evs = 0; evn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
    awa = 0; ara = 0; wd = 0;
    rows[0] = {8'h00, 32'h0, 2'b00};
    rows[1] = {8'h04, 32'hff, 2'b00};
    rows[2] = {8'h08, 32'hff, 2'b00};
    rows[3] = {8'h0c, 32'h0, 2'b00};
    rows[4] = {8'h10, 32'h0, 2'b00};
    rows[5] = {8'h14, 32'h0, 2'b00};
    rows[6] = {8'h18, 32'h0, 2'b10};
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    chk("pwm_n", pwm_n, 1);
    for (i = 0; i < 7; i = i + 1)
    begin
      rdr(rows[i][41:34]);
      chk("rdata", rd, rows[i][33:2]);
      chk("rresp", rs, rows[i][1:0]);
    end
    $display("done: reset values");
    // period 0x0102 crosses the byte boundary
    // low byte before high byte
    wr(8'h04, 8'h02); wr(8'h08, 8'h01);
    // initial-level bit kept zero in event mode
    wr(8'h00, 32'h71);
    chk("bresp", rs, 2'b00);
    ev(16'h0101, 0); rdr(8'h14);
    chk("count", rd, 32'h101);
    chk("irqs", irqs, 0);
    ev(16'h1, 1); rdr(8'h14);
    chk("irqs", irqs, 1);
    chk("count", rd, 0);
    ev(16'h2, 0); rdr(8'h14);
    chk("count", rd, 2);
    wr(8'h14, 0);
    chk("bresp", rs, 2'b10);
    wr(8'h00, 0); rdr(8'h14);
    chk("count", rd, 0);
    $display("done: event mode");
    // duty low byte before high byte
    wr(8'h0c, 0); wr(8'h10, 8'h80); rdr(8'h10);
    chk("duty", rd, 8'h80);
    // pin watched directly; duty rewritten far from any match
    wr(8'h00, 32'h63); wr(8'h0c, 0); wr(8'h10, 8'h20); rdr(8'h10);
    chk("duty", rd, 8'h80);
    @(negedge pwm_n); rdr(8'h14);
    chk("stat", rd[31:15], 17'h3);
    @(posedge irq); repeat (3) @(posedge aclk); @(negedge aclk);
    chk("pwm_n", pwm_n, 1);
    rdr(8'h10);
    chk("duty", rd, 8'h20);
    rdr(8'h14);
    chk("count hi", rd[15:8], 0);
    @(negedge pwm_n); wr(8'h00, 32'h62); repeat (20) @(posedge aclk); @(negedge aclk);
    chk("pwm_n", pwm_n, 0);
    wr(8'h00, 32'h66); wr(8'h00, 32'h62); @(negedge aclk);
    chk("pwm_n", pwm_n, 1);
    $display("done: pwm mode");
    // each prescaled source runs three periods, so three to five ticks
    src_run(8'h53, 6);
    chk("fc/2 count", rd[15:0] >= 3 && rd[15:0] <= 5, 1);
    src_run(8'h33, 24);
    chk("fc/8 count", rd[15:0] >= 3 && rd[15:0] <= 5, 1);
    src_run(8'h23, 96);
    chk("fc/32 count", rd[15:0] >= 3 && rd[15:0] <= 5, 1);
    src_run(8'h13, 384);
    chk("fc/128 count", rd[15:0] >= 3 && rd[15:0] <= 5, 1);
    src_run(8'h0b, 192);
    chk("fs/8 count", rd[15:0] >= 3 && rd[15:0] <= 5, 1);
    src_run(8'h03, 6144);
    chk("fc/2048 count", rd[15:0] >= 3 && rd[15:0] <= 5, 1);
    wr(8'h00, 32'h02);
    $display("done: prescaled sources");
    // fc sources give no ticks in slow mode, fs still does
    @(posedge aclk);
    slw <= 1;
    wr(8'h00, 32'h63); repeat (40) @(posedge aclk); rdr(8'h14);
    chk("count", rd[15:0], 0);
    wr(8'h00, 32'h43); repeat (80) @(posedge aclk); rdr(8'h14);
    chk("fs count", rd[15:0] != 16'h0, 1);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdr(8'h14);
    chk("count", rd, 0);
    chk("pwm_n", pwm_n, 1);
    $display("done: slow and reset");
    final_report;
  end
  // hang guard, tests need roughly 82000 cycles
  initial
  begin
    #(100000 * 10);
    err_total = err_total + 1;
    final_report;
  end
endmodule
